/* inc/sync_cfg_pkg.sv */
// shared constants and types for the frame sync output configuration bank
package sync_cfg_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] SYNC_PULSE_SHAPE_IDX = 8'h7a;
    localparam logic [7:0] SYNC_ALIGN_IDX = 8'h7b;
    localparam logic [31:0] SYNC_PULSE_SHAPE_ADDR =
        {22'h0, SYNC_PULSE_SHAPE_IDX, 2'h0};
    localparam logic [31:0] SYNC_ALIGN_ADDR =
        {22'h0, SYNC_ALIGN_IDX, 2'h0};

    // reset values
    localparam logic [7:0] SYNC_PULSE_SHAPE_RESET = 8'h00;
    localparam logic [7:0] SYNC_ALIGN_RESET = 8'h00;

    // writable bits; everything else reads as zero
    localparam logic [7:0] SYNC_PULSE_SHAPE_MASK = 8'h8f;
    localparam logic [7:0] SYNC_ALIGN_MASK = 8'hc0;

    // field positions, pulse shape register
    localparam int LOW_RATE_SRC_SECONDARY_PLL_BIT = 7;
    localparam int FRAME_PULSE_POLARITY_FLIP_BIT = 3;
    localparam int FRAME_PULSE_SHAPE_SEL_BIT = 2;
    localparam int MULTIFRAME_PULSE_POLARITY_FLIP_BIT = 1;
    localparam int MULTIFRAME_PULSE_SHAPE_SEL_BIT = 0;

    // field positions, alignment register
    localparam int SYNC_OUTPUTS_UNALIGNED_BIT = 7;
    localparam int SYNC_INPUT_FAST_SAMPLING_BIT = 6;

    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // period counter width: 2 kHz at 100 MHz is 50000 cycles
    localparam int PERIOD_CNT_W = 16;

    typedef struct packed {
        logic [7:0] shapeCfg;
        logic [7:0] alignCfg;
        logic wrShape;
        logic wrAlign;
        logic [31:0] rdata;
        logic genFrame;
        logic genMulti;
    } bank_state_t;

    typedef struct packed {
        logic syncStage1;
        logic syncStage2;
        logic sampled;
        logic fallEvent;
        logic fastActive;
    } sampler_state_t;

endpackage

/* verilog/sync_pulse_shaper.sv */
// one sync output waveform: square or width-reference pulse, with polarity
module sync_pulse_shaper #(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic periodTick,
    input wire logic widthRefEnable,
    input wire logic widthRefTick,
    input wire logic invertCfg,
    input wire logic pulseCfg,
    output logic pulseOut
);
    import sync_cfg_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] lastLen;
        logic level;
        logic armed;
        logic invAct;
        logic pulseAct;
        logic out;
    } shaper_state_t;

    shaper_state_t st;
    shaper_state_t nx;
    logic [CNT_W-1:0] halfLen;

    assign halfLen = st.lastLen >> 1;

    always_comb begin
        nx = st;
        if (st.cnt != '1) begin
            nx.cnt = st.cnt + 1'b1;
        end
        if (periodTick) begin
            // new settings only at a period boundary, so no runt edge
            nx.invAct = invertCfg;
            nx.pulseAct = pulseCfg;
            nx.lastLen = st.cnt + 1'b1;
            nx.cnt = '0;
            nx.level = !pulseCfg;
            nx.armed = pulseCfg;
        end else if (!st.pulseAct) begin
            if (st.cnt == halfLen) begin
                nx.level = 1'b0;
            end
        end else if (!widthRefEnable) begin
            // no reference clock: pulsed mode has nothing to time against
            nx.level = 1'b0;
            nx.armed = 1'b0;
        end else if (widthRefTick) begin
            if (st.level) begin
                nx.level = 1'b0;
            end else if (st.armed) begin
                nx.level = 1'b1;
                nx.armed = 1'b0;
            end
        end
        nx.out = nx.level ^ nx.invAct;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else if (ce) begin
            st <= nx;
        end
    end

    assign pulseOut = st.out;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    chk_flip_at_start: assert property (
        ce && periodTick && !pulseCfg |=> pulseOut == !$past(invertCfg))
        else $error("square output polarity wrong at period start");

    chk_square_half: assert property (
        ce && !periodTick && !st.pulseAct && st.cnt == halfLen
        |=> !st.level)
        else $error("square wave did not fall at half period");

    chk_pulse_rise: assert property (
        ce && !periodTick && st.pulseAct && widthRefEnable && st.armed
        && !st.level && widthRefTick |=> st.level)
        else $error("pulse did not start on reference tick");

    chk_pulse_end: assert property (
        ce && !periodTick && st.pulseAct && widthRefEnable && st.level
        && widthRefTick |=> !st.level)
        else $error("pulse longer than one reference period");

    chk_no_ref_quiet: assert property (
        ce && !periodTick && st.pulseAct && !widthRefEnable
        |=> !st.level ##0 pulseOut == st.invAct)
        else $error("pulse produced without reference output");

endmodule

/* verilog/sync_input_sampler.sv */
// external 2 kHz sync input: synchroniser, rate-selected sampling, edge
module sync_input_sampler (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic externalSyncInput,
    input wire logic slowSampleTick,
    input wire logic fastSampleTick,
    input wire logic currentClockFast,
    input wire logic fastSamplingCfg,
    output logic syncSampleLevel,
    output logic syncFallEvent,
    output logic fastSamplingActive
);
    import sync_cfg_pkg::*;

    sampler_state_t st;
    sampler_state_t nx;
    logic useFast;
    logic strobe;

    // fast sampling only pays off when the current clock is a fast one
    assign useFast = fastSamplingCfg && currentClockFast;
    assign strobe = useFast ? fastSampleTick : slowSampleTick;

    always_comb begin
        nx = st;
        nx.syncStage1 = externalSyncInput;
        nx.syncStage2 = st.syncStage1;
        nx.fallEvent = 1'b0;
        nx.fastActive = useFast;
        if (strobe) begin
            nx.sampled = st.syncStage2;
            nx.fallEvent = st.sampled && !st.syncStage2;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else if (ce) begin
            st <= nx;
        end
    end

    assign syncSampleLevel = st.sampled;
    assign syncFallEvent = st.fallEvent;
    assign fastSamplingActive = st.fastActive;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    chk_slow_rate: assert property (
        ce && !fastSamplingCfg |=> !fastSamplingActive)
        else $error("fast sampling used while disabled");

    chk_fast_rate: assert property (
        ce && fastSamplingCfg |=>
        fastSamplingActive == $past(currentClockFast))
        else $error("fast sampling selection wrong");

    chk_fall_detect: assert property (
        ce && strobe && st.sampled && !st.syncStage2 |=> syncFallEvent)
        else $error("falling edge of sync input missed");

endmodule

/* verilog/frame_sync_output_config.sv */
// frame and multiframe sync output configuration bank on ahb-lite
// Functional notes
// - shape bit 7 set takes the 2/8 kHz general ticks from the secondary pll.
// - the frame pulse polarity flip bit inverts the 8 kHz frame sync output.
// - the frame pulse shape bit picks pulsed or 50:50 square frame output.
// - frame pulses need the width reference output and last one period of it.
// - the multiframe polarity flip bit inverts the 2 kHz multiframe output.
// - the multiframe pulse shape bit picks pulsed or 50:50 multiframe output.
// - multiframe pulses need the width reference output, one period long.
// - the unaligned bit clear keeps sync outputs aligned, set frees them.
// - fast sampling clear samples the external sync input at 6.48 MHz.
// - fast sampling set uses a fast current clock, otherwise 6.48 MHz.
module frame_sync_output_config (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic primaryFrameTick,
    input wire logic primaryMultiTick,
    input wire logic secondaryFrameTick,
    input wire logic secondaryMultiTick,
    input wire logic freeFrameTick,
    input wire logic freeMultiTick,
    input wire logic widthRefEnable,
    input wire logic widthRefTick,
    input wire logic externalSyncInput,
    input wire logic slowSampleTick,
    input wire logic fastSampleTick,
    input wire logic currentClockFast,
    output logic generalFrameTick,
    output logic generalMultiTick,
    output logic framePulseOutput,
    output logic multiframePulseOutput,
    output logic syncSampleLevel,
    output logic syncFallEvent,
    output logic fastSamplingActive
);
    import sync_cfg_pkg::*;

    bank_state_t st;
    bank_state_t nx;

    logic addrPhase;
    logic hitShape;
    logic hitAlign;
    logic lowRateSrcSecondaryPll;
    logic framePulsePolarityFlip;
    logic framePulseShapeSel;
    logic multiframePulsePolarityFlip;
    logic multiframePulseShapeSel;
    logic syncOutputsUnaligned;
    logic syncInputFastSampling;
    logic frameTickSel;
    logic multiTickSel;

    assign lowRateSrcSecondaryPll =
        st.shapeCfg[LOW_RATE_SRC_SECONDARY_PLL_BIT];
    assign framePulsePolarityFlip = st.shapeCfg[FRAME_PULSE_POLARITY_FLIP_BIT];
    assign framePulseShapeSel = st.shapeCfg[FRAME_PULSE_SHAPE_SEL_BIT];
    assign multiframePulsePolarityFlip =
        st.shapeCfg[MULTIFRAME_PULSE_POLARITY_FLIP_BIT];
    assign multiframePulseShapeSel =
        st.shapeCfg[MULTIFRAME_PULSE_SHAPE_SEL_BIT];
    assign syncOutputsUnaligned = st.alignCfg[SYNC_OUTPUTS_UNALIGNED_BIT];
    assign syncInputFastSampling = st.alignCfg[SYNC_INPUT_FAST_SAMPLING_BIT];

    // zero wait states; a low clock enable stalls the bus with the bank
    assign hreadyout = ce;
    assign hresp = HRESP_OKAY;

    assign addrPhase = hsel && htrans[1] && hready;
    assign hitShape = haddr == SYNC_PULSE_SHAPE_ADDR;
    assign hitAlign = haddr == SYNC_ALIGN_ADDR;

    // aligned timing shares the output clocks' ticks; free timing does not
    assign frameTickSel = syncOutputsUnaligned ? freeFrameTick
                                               : primaryFrameTick;
    assign multiTickSel = syncOutputsUnaligned ? freeMultiTick
                                               : primaryMultiTick;

    always_comb begin
        nx = st;
        nx.wrShape = 1'b0;
        nx.wrAlign = 1'b0;
        // data phase of a write: only the low byte lane carries the bits
        if (st.wrShape) begin
            nx.shapeCfg = hwdata[7:0] & SYNC_PULSE_SHAPE_MASK;
        end
        if (st.wrAlign) begin
            nx.alignCfg = hwdata[7:0] & SYNC_ALIGN_MASK;
        end
        if (addrPhase) begin
            if (hwrite) begin
                nx.wrShape = hitShape;
                nx.wrAlign = hitAlign;
            end else if (hitShape) begin
                // read sees a write finishing in this same cycle
                nx.rdata = {24'h000000, nx.shapeCfg};
            end else if (hitAlign) begin
                nx.rdata = {24'h000000, nx.alignCfg};
            end else begin
                nx.rdata = 32'h00000000;
            end
        end
        nx.genFrame = lowRateSrcSecondaryPll ? secondaryFrameTick
                                             : primaryFrameTick;
        nx.genMulti = lowRateSrcSecondaryPll ? secondaryMultiTick
                                             : primaryMultiTick;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.shapeCfg <= SYNC_PULSE_SHAPE_RESET;
            st.alignCfg <= SYNC_ALIGN_RESET;
        end else if (ce) begin
            st <= nx;
        end
    end

    assign hrdata = st.rdata;
    assign generalFrameTick = st.genFrame;
    assign generalMultiTick = st.genMulti;

    sync_pulse_shaper #(
        .CNT_W(PERIOD_CNT_W)
    ) frameShaper (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .periodTick(frameTickSel),
        .widthRefEnable(widthRefEnable),
        .widthRefTick(widthRefTick),
        .invertCfg(framePulsePolarityFlip),
        .pulseCfg(framePulseShapeSel),
        .pulseOut(framePulseOutput)
    );

    sync_pulse_shaper #(
        .CNT_W(PERIOD_CNT_W)
    ) multiframeShaper (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .periodTick(multiTickSel),
        .widthRefEnable(widthRefEnable),
        .widthRefTick(widthRefTick),
        .invertCfg(multiframePulsePolarityFlip),
        .pulseCfg(multiframePulseShapeSel),
        .pulseOut(multiframePulseOutput)
    );

    sync_input_sampler syncSampler (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .externalSyncInput(externalSyncInput),
        .slowSampleTick(slowSampleTick),
        .fastSampleTick(fastSampleTick),
        .currentClockFast(currentClockFast),
        .fastSamplingCfg(syncInputFastSampling),
        .syncSampleLevel(syncSampleLevel),
        .syncFallEvent(syncFallEvent),
        .fastSamplingActive(fastSamplingActive)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence shapeWriteAddr;
        ce && addrPhase && hwrite && hitShape;
    endsequence

    sequence shapeWriteData;
        ce ##0 st.wrShape;
    endsequence

    sequence shapeReadAddr;
        ce && addrPhase && !hwrite && hitShape && !st.wrShape;
    endsequence

    chk_src_primary: assert property (
        ce && !lowRateSrcSecondaryPll && primaryFrameTick
        |=> generalFrameTick)
        else $error("primary path tick not forwarded");

    chk_src_secondary: assert property (
        ce && lowRateSrcSecondaryPll
        |=> generalMultiTick == $past(secondaryMultiTick))
        else $error("secondary path not selected");

    chk_aligned_frame: assert property (
        ce && !syncOutputsUnaligned && primaryFrameTick
        && !framePulseShapeSel
        |=> framePulseOutput == !$past(framePulsePolarityFlip))
        else $error("frame output not aligned to output clocks");

    chk_free_multiframe: assert property (
        ce && syncOutputsUnaligned && freeMultiTick
        && !multiframePulseShapeSel
        |=> multiframePulseOutput == !$past(multiframePulsePolarityFlip))
        else $error("multiframe output not on free timing");

    chk_write_mask: assert property (
        shapeWriteAddr ##1 shapeWriteData
        |=> st.shapeCfg == ($past(hwdata[7:0]) & SYNC_PULSE_SHAPE_MASK))
        else $error("pulse shape write not masked");

    chk_read_back: assert property (
        shapeReadAddr |=> hrdata == {24'h000000, st.shapeCfg})
        else $error("pulse shape read value wrong");

    chk_unused_zero: assert property (
        st.shapeCfg[6:4] == 3'h0 && st.alignCfg[5:0] == 6'h00
        && (st.rdata[31:8] == 24'h000000))
        else $error("unused bits not zero");

    chk_bus_ready: assert property (
        hreadyout == ce && hresp == HRESP_OKAY)
        else $error("bus response not ready or okay");

endmodule

/* bench/sync_pulse_monitor.sv */
// downstream sync consumer: measures the length of each high run of a pulse
module sync_pulse_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pulseIn,
    output logic runDone,
    output logic [15:0] runLen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt;
    // a run reports only once it ends; a stuck-high output never reports
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 16'h0;
            runDone <= 1'b0;
            runLen <= 16'h0;
        end else begin
            runDone <= 1'b0;
            if (pulseIn) begin
                cnt <= cnt + 16'h1;
            end else if (cnt != 16'h0) begin
                runLen <= cnt;
                runDone <= 1'b1;
                cnt <= 16'h0;
            end
        end
    end
endmodule

/* bench/frame_sync_output_config_tb.sv */
// self-checking bench for the frame sync output configuration bank
module frame_sync_output_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sync_cfg_pkg::*;
    typedef struct {
        logic [3:0] sel;
        logic [31:0] val;
        logic [7:0] tol;
    } note_t;
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp;
    logic [31:0] hrdata;
    logic primaryFrameTick = 1'b0, primaryMultiTick = 1'b0;
    logic secondaryFrameTick = 1'b0, secondaryMultiTick = 1'b0;
    logic freeFrameTick = 1'b0, freeMultiTick = 1'b0;
    logic widthRefEnable = 1'b1, widthRefTick = 1'b0;
    logic externalSyncInput = 1'b0, currentClockFast = 1'b0;
    logic slowSampleTick = 1'b0, fastSampleTick = 1'b0;
    logic generalFrameTick, generalMultiTick, framePulseOutput;
    logic multiframePulseOutput, syncSampleLevel, syncFallEvent;
    logic fastSamplingActive, fDone, mDone;
    logic [15:0] fLen, mLen;
    logic [3:0] tk;
    logic [31:0] rnd = 32'h13;
    logic [31:0] rdData = 32'h0;
    logic [31:0] seen, diff, fix;
    logic rdDone = 1'b0, probe = 1'b0, hit, isRun;
    logic [7:0] fallCnt = 8'h0, fallBase = 8'h0;
    note_t notes[$];
    note_t hd;
    int cyc = 0;
    int badCount = 0;
    int samplesChecked = 0;

    assign hready = hreadyout;
    assign tk = {secondaryMultiTick, primaryMultiTick,
                 secondaryFrameTick, primaryFrameTick};

    frame_sync_output_config dut_u (
        .clk, .rstn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout, .hresp,
        .primaryFrameTick, .primaryMultiTick, .secondaryFrameTick,
        .secondaryMultiTick, .freeFrameTick, .freeMultiTick,
        .widthRefEnable, .widthRefTick, .externalSyncInput,
        .slowSampleTick, .fastSampleTick, .currentClockFast,
        .generalFrameTick, .generalMultiTick, .framePulseOutput,
        .multiframePulseOutput, .syncSampleLevel, .syncFallEvent,
        .fastSamplingActive
    );
    sync_pulse_monitor fMon (.clk, .rstn, .pulseIn(framePulseOutput),
        .runDone(fDone), .runLen(fLen));
    sync_pulse_monitor mMon (.clk, .rstn, .pulseIn(multiframePulseOutput),
        .runDone(mDone), .runLen(mLen));

    always #5 clk = ~clk;

    // reference tick at phase 3 never meets a period tick, avoiding a tie
    always @(posedge clk) begin
        cyc <= cyc + 1;
        primaryFrameTick <= cyc % 40 == 0;
        secondaryFrameTick <= cyc % 40 == 20;
        primaryMultiTick <= cyc % 160 == 0;
        secondaryMultiTick <= cyc % 160 == 80;
        freeFrameTick <= cyc % 30 == 7;
        freeMultiTick <= cyc % 120 == 7;
        widthRefTick <= cyc % 6 == 3;
        slowSampleTick <= cyc % 15 == 0;
        fastSampleTick <= cyc % 5 == 0;
        if (syncFallEvent === 1'b1) fallCnt <= fallCnt + 8'h1;
        if (cyc == LIMIT) begin
            badCount++;
            conclude();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic obs(input logic [3:0] s);
        case (s)
            4'h3: return fastSamplingActive;
            4'h4: return generalFrameTick;
            4'h5: return generalMultiTick;
            4'h6: return framePulseOutput;
            4'h7: return multiframePulseOutput;
            4'h9: return fallCnt != fallBase;
            4'ha: return hresp;
            default: return syncSampleLevel;
        endcase
    endfunction

    always @(posedge clk) begin
        if (notes.size() > 0) begin
            hd = notes[0];
            isRun = hd.sel inside {4'h1, 4'h2};
            hit = hd.sel == 4'h0 ? rdDone : hd.sel == 4'h1 ? fDone
                : hd.sel == 4'h2 ? mDone : probe;
            seen = hd.sel == 4'h0 ? rdData : hd.sel == 4'h1 ? {16'h0, fLen}
                : hd.sel == 4'h2 ? {16'h0, mLen} : {31'h0, obs(hd.sel)};
            diff = seen > hd.val ? seen - hd.val : hd.val - seen;
            fix = diff <= {24'h0, hd.tol} ? hd.val : seen;
            if (hit && hd.sel == 4'h0) check(fix, hd.val);
            if (hit && isRun) check(fix, hd.val);
            if (hit && hd.sel > 4'h2) check(fix, hd.val);
            if (hit) void'(notes.pop_front());
        end
    end

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        samplesChecked++;
        if (s !== e) begin
            badCount++;
            $display("unexpected at %0t: saw %h wanted %h", $time, s, e);
        end
    endtask

    task automatic note(input logic [3:0] s, input logic [31:0] v,
                        input logic [7:0] t);
        notes.push_back('{s, v, t});
    endtask

    task automatic bus(input logic w, input logic [31:0] a, d, e);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rdData <= hrdata;
        rdDone <= !w;
        if (!w) note(4'h0, e, 8'h0);
        @(posedge clk);
        rdDone <= 1'b0;
    endtask

    task automatic probeLvl(input logic [3:0] s, input logic v);
        note(s, {31'h0, v}, 8'h0);
        probe <= 1'b1;
        @(posedge clk);
        probe <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wt(input int k);
        do @(posedge clk); while (tk[k] !== 1'b1);
    endtask

    task automatic drain;
        for (int i = 0; i < 2000 && notes.size() > 0; i++) @(posedge clk);
        if (notes.size() > 0) begin
            badCount++;
            $display("unexpected at %0t: results missing", $time);
            notes.delete();
        end
    endtask

    task automatic done(input string n);
        drain();
        $display("test %s done", n);
    endtask

    // settings latch on a period tick, so allow two long periods to settle
    task automatic runs(input logic [31:0] s, a, f, m, input logic [7:0] t);
        bus(1'b1, SYNC_PULSE_SHAPE_ADDR, s, 32'h0);
        bus(1'b1, SYNC_ALIGN_ADDR, a, 32'h0);
        repeat (400) @(posedge clk);
        repeat (2) note(4'h1, f, t);
        repeat (2) note(4'h2, m, t);
        done("waveform");
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        bus(1'b0, SYNC_PULSE_SHAPE_ADDR, 32'h0, 32'h0);
        bus(1'b0, SYNC_ALIGN_ADDR, 32'h0, 32'h0);
        bus(1'b1, SYNC_PULSE_SHAPE_ADDR, 32'hff, 32'h0);
        fork
            bus(1'b0, SYNC_PULSE_SHAPE_ADDR, 32'h0, 32'h8f);
            begin
                ce <= 1'b0;
                repeat (3) @(posedge clk);
                ce <= 1'b1;
            end
        join
        bus(1'b1, SYNC_ALIGN_ADDR, 32'hff, 32'h0);
        bus(1'b0, SYNC_ALIGN_ADDR, 32'h0, 32'hc0);
        repeat (4) begin
            rnd = xs(rnd);
            bus(1'b1, SYNC_PULSE_SHAPE_ADDR, rnd, 32'h0);
            bus(1'b0, SYNC_PULSE_SHAPE_ADDR, 32'h0, rnd & 32'h8f);
            bus(1'b1, SYNC_ALIGN_ADDR, rnd, 32'h0);
            bus(1'b0, SYNC_ALIGN_ADDR, 32'h0, rnd & 32'hc0);
        end
        bus(1'b1, 32'h1f0, 32'hff, 32'h0);
        bus(1'b0, 32'h1f0, 32'h0, 32'h0);
        probeLvl(4'ha, 1'b0);
        done("registers");
        for (int b = 0; b < 2; b++) begin
            bus(1'b1, SYNC_PULSE_SHAPE_ADDR, {24'h0, b[0], 7'h0}, 32'h0);
            for (int k = 0; k < 4; k++) begin
                wt(k);
                probeLvl(k < 2 ? 4'h4 : 4'h5, b[0] == k[0]);
            end
        end
        done("source select");
        runs(32'h0, 32'h0, 32'h14, 32'h50, 8'h2);
        for (int v = 0; v < 2; v++) begin
            bus(1'b1, SYNC_PULSE_SHAPE_ADDR, v ? 32'ha : 32'h0, 32'h0);
            repeat (400) @(posedge clk);
            wt(0);
            @(posedge clk);
            probeLvl(4'h6, !v);
            wt(2);
            @(posedge clk);
            probeLvl(4'h7, !v);
        end
        done("polarity");
        runs(32'h5, 32'h0, 32'h6, 32'h6, 8'h0);
        widthRefEnable <= 1'b0;
        repeat (400) @(posedge clk);
        repeat (50) begin
            probeLvl(4'h6, 1'b0);
            probeLvl(4'h7, 1'b0);
        end
        widthRefEnable <= 1'b1;
        done("reference off");
        runs(32'h0, 32'h80, 32'hf, 32'h3c, 8'h2);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, SYNC_ALIGN_ADDR, {25'h0, i[1], 6'h0}, 32'h0);
            currentClockFast <= i[0];
            repeat (3) @(posedge clk);
            probeLvl(4'h3, i[0] & i[1]);
            externalSyncInput <= 1'b1;
            repeat (40) @(posedge clk);
            fallBase = fallCnt;
            rnd = xs(rnd);
            externalSyncInput <= rnd[0];
            repeat (40) @(posedge clk);
            probeLvl(4'h8, rnd[0]);
            probeLvl(4'h9, !rnd[0]);
        end
        done("sampling");
        conclude();
    end
endmodule
